/* File: verif/cmpctl_analog_model.sv */
// model: analog comparator core and timer capture enable
`timescale 1ns/1ps
`default_nettype none
module cmpctl_analog_model #(
	parameter logic [7:0] REF_LVL = 8'h80 // fixed reference level
) (
	input  wire logic [7:0]      pos_lvl,   // positive pin
	input  wire logic [7:0]      neg_lvl,   // negative pin
	input  wire logic [7:0][7:0] chan_lvl,  // channel pins
	input  wire logic            power_off, // core off
	input  wire logic            ref_sel,   // reference on
	input  wire logic            mux_sel,   // channel on negative
	input  wire logic [2:0]      chan,      // channel
	input  wire logic            cap_in,    // capture front end
	input  wire logic            cap_ien,   // timer capture enable
	output logic                 raw,       // result
	output logic                 cap_irq    // timer request
);
	logic [7:0] p;
	logic [7:0] n;
	// steering; a powered-off core reports low rather than a stale result
	assign p = ref_sel ? REF_LVL : pos_lvl;
	assign n = mux_sel ? chan_lvl[chan] : neg_lvl;
	assign raw = !power_off && p > n;
	// the timer only raises its request with its own enable set
	assign cap_irq = cap_in && cap_ien;
endmodule
`default_nettype wire

/* File: verif/cmpctl_monitor.sv */
// checker: port timing of the comparator control top
`timescale 1ns/1ps
`default_nettype none
module cmpctl_monitor (
	input wire logic        pclk,                 // clock
	input wire logic        presetn,              // reset, low
	input wire logic        psel,                 // apb select
	input wire logic        penable,              // apb enable
	input wire logic        pwrite,               // apb write
	input wire logic [11:0] paddr,                // apb address
	input wire logic [31:0] pwdata,               // write data
	input wire logic [3:0]  pstrb,                // strobes
	input wire logic [31:0] prdata,               // read data
	input wire logic        pready,               // ready
	input wire logic        comparator_raw,       // raw result
	input wire logic        converter_enable,     // converter on
	input wire logic        global_irq_enable,    // global enable
	input wire logic        irq_vector_ack,       // vector pulse
	input wire logic        comparator_power_off, // power off
	input wire logic        positive_ref_select,  // reference
	input wire logic        negative_mux_select,  // mux select
	input wire logic        capture_input,        // capture out
	input wire logic        comparator_irq        // request
);
	// ==========================================================
	// sequences
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// long enough that no event is still in the sync pipe
	sequence raw_steady;
		$stable(comparator_raw) [*6];
	endsequence
	sequence ctrl_acc;
		pready && psel && penable && paddr == cmpctl_pkg::ADDR_CTRL_STATUS;
	endsequence
	sequence ctrl_wr;
		ctrl_acc ##0 pwrite && pstrb[0];
	endsequence
	// ==========================================================
	// assertions
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	a_result_synced: assert property (raw_steady ##0 ctrl_acc ##0 !pwrite |->
		prdata[5] == comparator_raw) else $error("result bit wrong");
	a_ctrl_write_out: assert property (ctrl_wr |=>
		{comparator_power_off, positive_ref_select} == $past(pwdata[7:6]))
		else $error("power or reference output wrong");
	a_flag_one_clears: assert property (raw_steady ##0 ctrl_wr ##0 pwdata[4] |=>
		!comparator_irq) else $error("flag not cleared by write");
	a_vector_clears: assert property (raw_steady ##0 irq_vector_ack |=>
		!comparator_irq) else $error("flag not cleared by vector");
	a_irq_needs_global: assert property (comparator_irq |-> $past(global_irq_enable))
		else $error("request without global enable");
	a_mux_needs_off: assert property (negative_mux_select |-> !$past(converter_enable))
		else $error("mux selected while converter on");
	a_capture_quiet: assert property (!comparator_raw [*5] |-> !capture_input)
		else $error("capture high without result");
endmodule
bind cmpctl_top cmpctl_monitor mon (.*);
`default_nettype wire

/* File: verif/test_comparator_control_logic.sv */
// testbench: apb and comparator stimulus for the comparator control top
`timescale 1ns/1ps
`default_nettype none
module test_comparator_control_logic;
	localparam logic [7:0] REF_LVL = 8'h80;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, comparator_raw, irq;
	logic converter_enable, global_irq_enable, irq_vector_ack, comparator_power_off;
	logic positive_ref_select, negative_mux_select, capture_input, comparator_irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, r;
	logic [3:0] pstrb;
	logic [2:0] converter_channel_field, negative_channel, st, msk;
	logic [7:0] pos_lvl, neg_lvl, ctl;
	logic [7:0][7:0] chan_lvl;
	logic cur, fl, sp, er;
	logic cap_ien, cap_irq; // timer capture enable and the timer's request
	int error_cnt = 0, num_checks = 0, seed = 43952;
	cmpctl_top dut (.*);
	cmpctl_analog_model #(.REF_LVL(REF_LVL)) core (.pos_lvl, .neg_lvl, .chan_lvl,
		.power_off(comparator_power_off), .ref_sel(positive_ref_select),
		.mux_sel(negative_mux_select), .chan(negative_channel), .cap_in(capture_input),
		.cap_ien(cap_ien), .raw(comparator_raw), .cap_irq(cap_irq));
	// ==========================================================
	// helpers
	initial begin
		pclk = 0;
		forever #10 pclk = ~pclk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// one transfer, request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// result the core should give for the stimulus applied (off core reads low)
	function automatic logic exp_raw();
		logic [7:0] p, n;
		p = ctl[6] ? REF_LVL : pos_lvl;
		n = (sp && !converter_enable) ? chan_lvl[converter_channel_field] : neg_lvl;
		return !ctl[7] && p > n;
	endfunction
	// let the result settle, then fold its edges into flag and status
	task automatic settle();
		logic n;
		logic [2:0] e;
		tick(6);
		n = exp_raw();
		e = {cur && !n, !cur && n, 1'b0};
		e[0] = ctl[1:0] == 2'h0 ? |e : ctl[1:0] == 2'h1 ? 1'b0 : ctl[0] ? e[1] : e[2];
		fl |= e[0];
		st |= e;
		cur = n;
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ==========================================================
	// tests
	initial begin
		{psel, penable, pwrite, paddr, pwdata, irq_vector_ack, sp, cur, fl, st} = '0;
		{converter_enable, converter_channel_field, global_irq_enable, ctl, cap_ien} = '0;
		{pos_lvl, neg_lvl, pstrb, presetn} = {16'h0, 4'hF, 1'b0};
		for (int i = 0; i < 8; i++) chan_lvl[i] = $random(seed);
		tick(2);
		presetn <= 1;
		for (int a = 0; a < 20; a += 4) begin
			apb(0, a[11:0], 0);
			chk("reset_value", 0, rd);
			chk("slverr", a == 16, er);
		end
		apb(1, 12'h010, 32'hFF);
		chk("write_slverr", 1, er);
		$display("test reset done");
		for (int i = 0; i < 40; i++) begin
			r = $random(seed);
			{pos_lvl, neg_lvl} <= r[15:0];
			{converter_enable, converter_channel_field, global_irq_enable} <= r[20:16];
			cap_ien <= r[7];
			settle();
			sp = r[21];
			apb(1, cmpctl_pkg::ADDR_SPECIAL_IO, {sp, 3'h0});
			settle();
			apb(1, cmpctl_pkg::ADDR_CTRL_STATUS, {r[31:29], r[22], 1'b0, r[25:23]});
			ctl = {r[31:29], 2'h0, r[25:23]};
			if (r[22]) fl = 0;
			settle();
			ctl[3] = r[26];
			apb(1, cmpctl_pkg::ADDR_CTRL_STATUS, ctl);
			msk = r[10:8];
			apb(1, cmpctl_pkg::ADDR_IRQ_MASK, msk);
			apb(0, cmpctl_pkg::ADDR_CTRL_STATUS, 0);
			chk("result", cur, rd[5]);
			chk("flag", fl, rd[4]);
			chk("cmp_irq", fl & ctl[3] & global_irq_enable, comparator_irq);
			chk("neg_mux", {sp & !converter_enable, converter_channel_field},
				{negative_mux_select, negative_channel});
			chk("capture", ctl[2] & cur, capture_input);
			chk("cap_irq", ctl[2] & cur & cap_ien, cap_irq);
			chk("power_ref", ctl[7:6], {comparator_power_off, positive_ref_select});
			apb(0, cmpctl_pkg::ADDR_IRQ_STATUS, 0);
			chk("status", st, rd);
			chk("irq", |(st & msk), irq);
			if (r[27]) begin
				irq_vector_ack <= 1;
				tick(1);
				irq_vector_ack <= 0;
				fl = 0;
				tick(2);
				chk("ack_clear", 0, comparator_irq);
			end
			apb(1, cmpctl_pkg::ADDR_IRQ_STATUS, r[28:26]);
			st &= ~r[28:26];
		end
		$display("test random done");
		tally_and_finish();
	end
	// watchdog well past the expected run length
	initial begin
		tick(10000);
		error_cnt++;
		tally_and_finish();
	end
endmodule
`default_nettype wire

/* File: verilog/cmpctl_pkg.sv */
// package: register map, field positions, reset values and event modes of the comparator control
package cmpctl_pkg;
	// ==========================================================
	// register byte addresses on the apb bus
	localparam logic [11:0] ADDR_CTRL_STATUS = 12'h000; // comparator_control_status
	localparam logic [11:0] ADDR_SPECIAL_IO  = 12'h004; // special_function_io
	localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h008; // sticky event status, write one clears
	localparam logic [11:0] ADDR_IRQ_MASK    = 12'h00C; // mask for the level interrupt output
	// ==========================================================
	// comparator_control_status field positions
	localparam int BIT_POWER_OFF  = 7;
	localparam int BIT_REF_SELECT = 6;
	localparam int BIT_RESULT     = 5;
	localparam int BIT_EVENT_FLAG = 4;
	localparam int BIT_IRQ_ENABLE = 3;
	localparam int BIT_CAPTURE    = 2;
	localparam int BIT_MODE_HI    = 1;
	localparam int BIT_MODE_LO    = 0;
	// special_function_io field position
	localparam int BIT_NEG_MUX_EN = 3;
	// irq status / mask layout
	localparam int IRQ_EVENT  = 0; // comparator event matched the mode
	localparam int IRQ_RISE   = 1; // any rising edge of the result
	localparam int IRQ_FALL   = 2; // any falling edge of the result
	localparam int IRQ_BITS   = 3;
	// ==========================================================
	// reset values
	localparam logic [7:0] RST_CTRL    = 8'h00;
	localparam logic [7:0] RST_SPECIAL = 8'h00;
	localparam logic [2:0] RST_IRQ     = 3'h0;
	localparam logic [1:0] SYNC_RST    = 2'h0;
	// ==========================================================
	// event mode codes
	typedef enum logic [1:0] {
		CMPCTL_MODE_TOGGLE   = 2'h0,
		CMPCTL_MODE_RESERVED = 2'h1,
		CMPCTL_MODE_FALL     = 2'h2,
		CMPCTL_MODE_RISE     = 2'h3
	} cmpctl_mode_e;
endpackage

/* File: verilog/cmpctl_sync.sv */
// file: two-stage synchroniser for the raw comparator result
`timescale 1ns/1ps
`default_nettype none
module cmpctl_sync (
	input  wire logic pclk,    // system clock
	input  wire logic presetn, // async reset, active low
	input  wire logic d_in,    // asynchronous level
	output logic      q_out    // synchronised level
);
	logic meta_r;
	// ==========================================================
	// first stage feeds only the second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= 1'b0;
			q_out  <= 1'b0;
		end else begin
			meta_r <= d_in;
			q_out  <= meta_r;
		end
	end
endmodule
`default_nettype wire

/* File: verilog/cmpctl_top.sv */
// file: comparator control, event detect, interrupt and capture routing with apb registers
// Functional notes
// - result bit is synchronised, one-two cycle lag
// - result one when positive input above negative
// - mux enable and converter off steer channel
// - power-off bit removes comparator power
// - reference select feeds fixed reference positive
// - matching event sets flag regardless of enable
// - request needs flag, enable and global enable
// - flag clears when processor vectors to handler
// - writing one clears flag, zero keeps
// - capture route drives timer capture front end
// - route off means no capture connection
// - mode: toggle, reserved, falling, rising
// - channel field picks negative analog channel
`timescale 1ns/1ps
`default_nettype none
module cmpctl_top (
	input  wire logic        pclk,                // system clock, 50 MHz
	input  wire logic        presetn,             // async reset, active low
	input  wire logic        psel,                // apb select
	input  wire logic        penable,             // apb access phase
	input  wire logic        pwrite,              // apb direction
	input  wire logic [11:0] paddr,               // apb byte address
	input  wire logic [31:0] pwdata,              // apb write data
	input  wire logic [3:0]  pstrb,               // apb byte strobes
	output logic      [31:0] prdata,              // apb read data
	output logic             pready,              // apb ready
	output logic             pslverr,             // apb error on unmapped address
	input  wire logic        comparator_raw,      // analog core result, pos above neg
	input  wire logic        converter_enable,    // converter switched on
	input  wire logic [2:0]  converter_channel_field, // converter channel select
	input  wire logic        global_irq_enable,   // processor global interrupt enable
	input  wire logic        irq_vector_ack,      // pulse: processor vectors to handler
	output logic             comparator_power_off,// power down to analog core
	output logic             positive_ref_select, // 1: fixed reference on positive input
	output logic             negative_mux_select, // 1: channel mux drives negative input
	output logic      [2:0]  negative_channel,    // channel routed to negative input
	output logic             capture_input,       // to timer capture front end
	output logic             comparator_irq,      // comparator interrupt request
	output logic             irq                  // masked sticky status interrupt
);
	// ==========================================================
	// registers
	logic [7:0] ctrl_r;
	logic [7:0] special_r;
	logic [2:0] irq_status_r;
	logic [2:0] irq_mask_r;
	logic       result_prev_r;
	logic       result_sync;
	logic       flag_r;

	// ==========================================================
	// synchroniser: two flops give one to two cycles of lag
	cmpctl_sync u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d_in    (comparator_raw),
		.q_out   (result_sync)
	);

	// ==========================================================
	// apb decode
	wire access    = psel & penable;
	wire wr_en     = access & pwrite & pstrb[0];
	wire hit_ctrl  = paddr == cmpctl_pkg::ADDR_CTRL_STATUS;
	wire hit_spec  = paddr == cmpctl_pkg::ADDR_SPECIAL_IO;
	wire hit_stat  = paddr == cmpctl_pkg::ADDR_IRQ_STATUS;
	wire hit_mask  = paddr == cmpctl_pkg::ADDR_IRQ_MASK;
	wire mapped    = hit_ctrl | hit_spec | hit_stat | hit_mask;
	wire wr_ctrl   = wr_en & hit_ctrl;
	wire wr_spec   = wr_en & hit_spec;
	wire wr_stat   = wr_en & hit_stat;
	wire wr_mask   = wr_en & hit_mask;

	// ==========================================================
	// event detection against the previous synchronised sample
	wire rise_ev  = result_sync & ~result_prev_r;
	wire fall_ev  = ~result_sync & result_prev_r;
	wire [1:0] mode = ctrl_r[cmpctl_pkg::BIT_MODE_HI:cmpctl_pkg::BIT_MODE_LO];
	wire mode_tog = mode == cmpctl_pkg::CMPCTL_MODE_TOGGLE;
	wire mode_fal = mode == cmpctl_pkg::CMPCTL_MODE_FALL;
	wire mode_ris = mode == cmpctl_pkg::CMPCTL_MODE_RISE;
	// reserved code matches nothing, so it never raises the flag
	wire match_ev = (mode_tog & (rise_ev | fall_ev)) |
		(mode_fal & fall_ev) | (mode_ris & rise_ev);
	wire [2:0] ev_vec = {fall_ev, rise_ev, match_ev};

	// ==========================================================
	// flag clear sources; a new event wins over any clear
	wire flag_wr_clr = wr_ctrl & pwdata[cmpctl_pkg::BIT_EVENT_FLAG];
	wire flag_clr    = flag_wr_clr | irq_vector_ack;
	wire flag_nxt    = match_ev | (flag_r & ~flag_clr);

	// ==========================================================
	// routing to the analog core and the timer
	wire irq_en      = ctrl_r[cmpctl_pkg::BIT_IRQ_ENABLE];
	wire route_cap   = ctrl_r[cmpctl_pkg::BIT_CAPTURE];
	wire neg_mux_nxt = special_r[cmpctl_pkg::BIT_NEG_MUX_EN] & ~converter_enable;
	wire cap_nxt     = route_cap & result_sync;
	wire creq_nxt    = flag_nxt & irq_en & global_irq_enable;
	wire [2:0] stat_nxt = ev_vec | (irq_status_r & ~(pwdata[2:0] & {3{wr_stat}}));
	wire irq_nxt     = |(stat_nxt & irq_mask_r);

	// ==========================================================
	// read mux; the result bit is live, other bits from registers
	wire [7:0] ctrl_rd = {ctrl_r[7:6], result_sync, flag_r, ctrl_r[3:0]};
	wire [31:0] rd_nxt =
		hit_ctrl ? {24'h000000, ctrl_rd} :
		hit_spec ? {24'h000000, special_r} :
		hit_stat ? {29'h00000000, irq_status_r} :
		hit_mask ? {29'h00000000, irq_mask_r} : 32'h00000000;

	// ==========================================================
	// control registers; writes only land on the apb access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r    <= cmpctl_pkg::RST_CTRL;
			special_r <= cmpctl_pkg::RST_SPECIAL;
		end else begin
			if (wr_ctrl) begin
				// result and flag positions are not stored from the bus
				ctrl_r <= pwdata[7:0] & 8'hCF;
			end
			if (wr_spec) begin
				special_r <= pwdata[7:0];
			end
		end
	end

	// ==========================================================
	// event flag, previous sample and sticky status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_r        <= 1'b0;
			result_prev_r <= 1'b0;
			irq_status_r  <= cmpctl_pkg::RST_IRQ;
			irq_mask_r    <= cmpctl_pkg::RST_IRQ;
		end else begin
			flag_r        <= flag_nxt;
			result_prev_r <= result_sync;
			irq_status_r  <= stat_nxt;
			if (wr_mask) begin
				irq_mask_r <= pwdata[2:0];
			end
		end
	end

	// ==========================================================
	// registered outputs; zero wait states keep the bus simple
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata               <= 32'h00000000;
			pready               <= 1'b0;
			pslverr              <= 1'b0;
			comparator_power_off <= 1'b0;
			positive_ref_select  <= 1'b0;
			negative_mux_select  <= 1'b0;
			negative_channel     <= 3'h0;
			capture_input        <= 1'b0;
			comparator_irq       <= 1'b0;
			irq                  <= 1'b0;
		end else begin
			pready               <= psel & ~penable;
			pslverr              <= psel & ~penable & ~mapped;
			prdata               <= (psel & ~penable & ~pwrite) ? rd_nxt : 32'h00000000;
			comparator_power_off <= wr_ctrl ? pwdata[cmpctl_pkg::BIT_POWER_OFF] :
				ctrl_r[cmpctl_pkg::BIT_POWER_OFF];
			positive_ref_select  <= wr_ctrl ? pwdata[cmpctl_pkg::BIT_REF_SELECT] :
				ctrl_r[cmpctl_pkg::BIT_REF_SELECT];
			negative_mux_select  <= neg_mux_nxt;
			negative_channel     <= converter_channel_field;
			capture_input        <= cap_nxt;
			comparator_irq       <= creq_nxt;
			irq                  <= irq_nxt;
		end
	end
endmodule
`default_nettype wire
